// [chgip_pkg.sv]
// constants, encodings and register layout for the charger serial register port
// Notes on behaviour
// R1: only 7-bit addressing; ignore 10-bit headers
// R2: answer fixed bus address 0x6A only
// R3: standard and fast mode, same protocol
// R4: detect START: data falls, clock high
// R5: detect STOP: data rises, clock high
// R6: controller keeps data stable while clock high
// R7: acknowledge address match through ninth clock high
// R8: receiver of each byte acknowledges it
// R9: unlimited nine-clock byte units per transfer
// R10: after STOP stay idle until addressed
// R11: controller sends STOP to abandon transfer
// R12: unmapped offset reads return FFh
// R13: decode thirteen byte registers, offsets 0-0xC
// R14: host never writes reserved offsets
// R15: registers lost only on shutdown/UVLO
// R16: write offset first; read via repeated START
// R17: read-to-clear bits clear after completed read
`default_nettype none
package chgip_pkg;

	localparam logic [6:0] DEV_ADDR      = 7'h6a;
	localparam logic [2:0] BIT_LAST      = 3'h7;
	localparam logic [7:0] UNMAPPED_BYTE = 8'hff;

	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_FAULT  = 8'h01;
	localparam logic [7:0] OFS_FLAGS  = 8'h02;
	localparam logic [7:0] OFS_VBAT   = 8'h03;
	localparam logic [7:0] OFS_ICHG   = 8'h04;
	localparam logic [7:0] OFS_CTRL0  = 8'h05;
	localparam logic [7:0] OFS_CTRL1  = 8'h06;
	localparam logic [7:0] OFS_CHIP   = 8'h07;
	localparam logic [7:0] OFS_TMR    = 8'h08;
	localparam logic [7:0] OFS_SHIP   = 8'h09;
	localparam logic [7:0] OFS_SYS    = 8'h0a;
	localparam logic [7:0] OFS_TS     = 8'h0b;
	localparam logic [7:0] OFS_MASK   = 8'h0c;

	localparam int CTRL_NUM = 9;

	// control register defaults, index 0 is offset 0x3
	localparam logic [CTRL_NUM-1:0][7:0] CTRL_RESET = {
		8'h00,  // thermistor_ctrl
		8'h00,  // system_rail_ctrl
		8'h00,  // shipping_reset_button_ctrl
		8'h00,  // timer_input_limit_ctrl
		8'h84,  // chip_ctrl
		8'h56,  // charger_ctrl_second
		8'h2c,  // charger_ctrl_first
		8'h05,  // fast_charge_current_ctrl
		8'h46   // battery_voltage_ctrl
	};

	localparam logic [3:0] MASK_RESET = 4'h0;
	// identification nibble: value is arbitrary
	localparam logic [3:0] IDENT_CODE = 4'h5;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RX    = 3'b001,
		ST_ACKW  = 3'b010,
		ST_ACK   = 3'b011,
		ST_TX    = 3'b100,
		ST_TXEND = 3'b101,
		ST_RACK  = 3'b110,
		ST_RACKF = 3'b111
	} chgip_fsm_t;

	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_OFS  = 2'b01,
		PH_DATA = 2'b10
	} chgip_phase_t;

endpackage
`default_nettype wire

// [chgip_charger_i2c_register_port.sv]
// serial bus target and register bank of the battery charger
`timescale 1ns/1ps
`default_nettype none
module chgip_charger_i2c_register_port (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe,
	input  wire logic                 reg_lost_i,
	input  wire logic [7:0]           charger_status_i,
	input  wire logic [4:0]           fault_level_i,
	input  wire logic [2:0]           fault_event_i,
	input  wire logic [7:0]           flag_event_i,
	output logic [7:0]                battery_voltage_ctrl,
	output logic [7:0]                fast_charge_current_ctrl,
	output logic [7:0]                charger_ctrl_first,
	output logic [7:0]                charger_ctrl_second,
	output logic [7:0]                chip_ctrl,
	output logic [7:0]                timer_input_limit_ctrl,
	output logic [7:0]                shipping_reset_button_ctrl,
	output logic [7:0]                system_rail_ctrl,
	output logic [7:0]                thermistor_ctrl,
	output logic [3:0]                irq_mask
);
	import chgip_pkg::*;

	typedef struct packed {
		chgip_fsm_t                  st;
		chgip_phase_t                phase;
		logic [2:0]                  bitcnt;
		logic [7:0]                  shreg;
		logic [7:0]                  txbyte;
		logic                        rw;
		logic [7:0]                  ptr;
		logic                        scl_s1;
		logic                        scl_s2;
		logic                        scl_d;
		logic                        sda_s1;
		logic                        sda_s2;
		logic                        sda_d;
		logic                        sda_oe;
		logic                        sda_out;
		logic [2:0]                  fault_sticky;
		logic [7:0]                  flags;
		logic [CTRL_NUM-1:0][7:0]    ctrl;
		logic [3:0]                  mask;
	} chgip_state_t;

	chgip_state_t s_reg;
	chgip_state_t s_next;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic [7:0] rx_byte;
	logic [7:0] rd_now;
	logic [3:0] ctrl_idx;
	logic       ptr_is_ctrl;
	logic [7:0] clr_flags;
	logic [2:0] clr_fault;
	logic       load_tx;

	////////////////////////////////////////////////////////////////////////////////
	// bus conditions, taken from the second synchroniser stage and its one-cycle delayed copy

	assign scl_rise  = s_reg.scl_s2 & ~s_reg.scl_d;
	assign scl_fall  = ~s_reg.scl_s2 & s_reg.scl_d;
	assign start_det = s_reg.scl_s2 & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s2;  // R4
	assign stop_det  = s_reg.scl_s2 & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s2;  // R5
	assign rx_byte   = {s_reg.shreg[6:0], s_reg.sda_s2};

	assign ptr_is_ctrl = (s_reg.ptr >= OFS_VBAT) && (s_reg.ptr <= OFS_TS);
	assign ctrl_idx    = s_reg.ptr[3:0] - OFS_VBAT[3:0];

	////////////////////////////////////////////////////////////////////////////////
	// read decode

	always_comb begin
		rd_now = UNMAPPED_BYTE;  // R12
		case (s_reg.ptr)  // R13
			OFS_STATUS: rd_now = charger_status_i;
			OFS_FAULT:  rd_now = {fault_level_i, s_reg.fault_sticky};
			OFS_FLAGS:  rd_now = s_reg.flags;
			OFS_MASK:   rd_now = {s_reg.mask, IDENT_CODE};
			default: begin
				if (ptr_is_ctrl) begin
					rd_now = s_reg.ctrl[ctrl_idx];
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_next    = s_reg;
		clr_flags = 8'h00;
		clr_fault = 3'h0;
		load_tx   = 1'b0;

		s_next.scl_s1 = scl_i;
		s_next.scl_s2 = s_reg.scl_s1;
		s_next.scl_d  = s_reg.scl_s2;
		s_next.sda_s1 = sda_i;
		s_next.sda_s2 = s_reg.sda_s1;
		s_next.sda_d  = s_reg.sda_s2;

		// start wins over everything except register loss so a repeated start restarts addressing
		if (start_det) begin  // R4 R16
			s_next.st     = ST_RX;
			s_next.phase  = PH_ADDR;
			s_next.bitcnt = 3'h0;
			s_next.sda_oe = 1'b0;
		end else if (stop_det) begin  // R5 R10
			s_next.st     = ST_IDLE;
			s_next.sda_oe = 1'b0;
		end else begin
			case (s_reg.st)
				ST_IDLE: begin
				end
				// data is taken on the rising clock edge only; it changes while low
				ST_RX: begin
					if (scl_rise) begin  // R3 R6
						s_next.shreg  = rx_byte;
						s_next.bitcnt = s_reg.bitcnt + 3'h1;
						if (s_reg.bitcnt == BIT_LAST) begin  // R9
							s_next.st = ST_ACKW;
							case (s_reg.phase)
								PH_ADDR: begin
									// a 10-bit header never equals our address
									if (rx_byte[7:1] == DEV_ADDR) begin  // R1 R2 R7
										s_next.rw    = rx_byte[0];
										s_next.phase = PH_OFS;
									end else begin
										s_next.st = ST_IDLE;
									end
								end
								PH_OFS: begin  // R16
									s_next.ptr   = rx_byte;
									s_next.phase = PH_DATA;
								end
								default: begin  // R8 R13
									if (ptr_is_ctrl) begin
										s_next.ctrl[ctrl_idx] = rx_byte;
									end else if (s_reg.ptr == OFS_MASK) begin
										s_next.mask = rx_byte[7:4];
									end
									s_next.ptr = s_reg.ptr + 8'h01;
								end
							endcase
						end
					end
				end
				ST_ACKW: begin
					if (scl_fall) begin  // R7 R8
						s_next.sda_oe = 1'b1;
						s_next.st     = ST_ACK;
					end
				end
				// acknowledge is held through the whole ninth high phase
				ST_ACK: begin
					if (scl_fall) begin
						if (s_reg.rw) begin
							load_tx = 1'b1;
						end else begin
							s_next.sda_oe = 1'b0;
							s_next.st     = ST_RX;
							s_next.bitcnt = 3'h0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						s_next.bitcnt = s_reg.bitcnt + 3'h1;
						if (s_reg.bitcnt == BIT_LAST) begin
							s_next.st = ST_TXEND;
						end
					end else if (scl_fall) begin
						s_next.shreg  = {s_reg.shreg[6:0], 1'b0};
						s_next.sda_oe = ~s_reg.shreg[6];
					end
				end
				ST_TXEND: begin
					if (scl_fall) begin
						s_next.sda_oe = 1'b0;
						s_next.st     = ST_RACK;
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						// only bits that went out are cleared, later events survive
						if (s_reg.ptr == OFS_FLAGS) begin  // R17
							clr_flags = s_reg.txbyte;
						end
						if (s_reg.ptr == OFS_FAULT) begin  // R17
							clr_fault = s_reg.txbyte[2:0];
						end
						s_next.ptr = s_reg.ptr + 8'h01;
						s_next.st  = s_reg.sda_s2 ? ST_IDLE : ST_RACKF;  // R8
					end
				end
				ST_RACKF: begin
					if (scl_fall) begin  // R9
						load_tx = 1'b1;
					end
				end
				default: begin
					s_next.st = ST_IDLE;
				end
			endcase
		end

		// read data is sampled at the falling edge that starts the byte
		if (load_tx) begin
			s_next.txbyte = rd_now;
			s_next.shreg  = rd_now;
			s_next.sda_oe = ~rd_now[7];
			s_next.bitcnt = 3'h0;
			s_next.st     = ST_TX;
		end

		// hardware set wins over a read clear in the same cycle
		s_next.flags        = (s_reg.flags & ~clr_flags) | flag_event_i;
		s_next.fault_sticky = (s_reg.fault_sticky & ~clr_fault) | fault_event_i;

		if (reg_lost_i) begin  // R15
			s_next.ctrl         = CTRL_RESET;
			s_next.mask         = MASK_RESET;
			s_next.flags        = 8'h00;
			s_next.fault_sticky = 3'h0;
			s_next.st           = ST_IDLE;
			s_next.sda_oe       = 1'b0;
			s_next.ptr          = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg        <= '0;
			s_reg.st     <= ST_IDLE;
			s_reg.phase  <= PH_ADDR;
			s_reg.ctrl   <= CTRL_RESET;
			s_reg.mask   <= MASK_RESET;
			s_reg.scl_s1 <= 1'b1;
			s_reg.scl_s2 <= 1'b1;
			s_reg.scl_d  <= 1'b1;
			s_reg.sda_s1 <= 1'b1;
			s_reg.sda_s2 <= 1'b1;
			s_reg.sda_d  <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign sda_o                      = s_reg.sda_out;
	assign sda_oe                     = s_reg.sda_oe;
	assign battery_voltage_ctrl       = s_reg.ctrl[0];
	assign fast_charge_current_ctrl   = s_reg.ctrl[1];
	assign charger_ctrl_first         = s_reg.ctrl[2];
	assign charger_ctrl_second        = s_reg.ctrl[3];
	assign chip_ctrl                  = s_reg.ctrl[4];
	assign timer_input_limit_ctrl     = s_reg.ctrl[5];
	assign shipping_reset_button_ctrl = s_reg.ctrl[6];
	assign system_rail_ctrl           = s_reg.ctrl[7];
	assign thermistor_ctrl            = s_reg.ctrl[8];
	assign irq_mask                   = s_reg.mask;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_start_addr;
		@(posedge clk) disable iff (!rst_n)
		start_det && !reg_lost_i |=> s_reg.st == ST_RX && s_reg.phase == PH_ADDR && s_reg.bitcnt == 3'h0;
	endproperty
	a_start_addr: assert property (p_start_addr) else $error("start not taken");  // R4

	property p_stop_idle;
		@(posedge clk) disable iff (!rst_n)
		stop_det && !start_det |=> s_reg.st == ST_IDLE && !sda_oe;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not free bus");  // R5

	property p_idle_quiet;
		@(posedge clk) disable iff (!rst_n)
		s_reg.st == ST_IDLE && !start_det |=> s_reg.st == ST_IDLE && !sda_oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("left idle without start");  // R10

	property p_addr_filter;
		@(posedge clk) disable iff (!rst_n)
		s_reg.st == ST_RX && s_reg.phase == PH_ADDR && scl_rise && s_reg.bitcnt == BIT_LAST
			&& !start_det && !stop_det && !reg_lost_i
		|=> (s_reg.st == ST_ACKW) == ($past(rx_byte[7:1]) == DEV_ADDR);
	endproperty
	a_addr_filter: assert property (p_addr_filter) else $error("address match wrong");  // R2

	property p_ack_hold;
		@(posedge clk) disable iff (!rst_n)
		s_reg.st == ST_ACKW && scl_fall && !start_det && !stop_det && !reg_lost_i
		|=> sda_oe && s_reg.st == ST_ACK;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack not driven");  // R7

	property p_ack_stable;
		@(posedge clk) disable iff (!rst_n)
		s_reg.st == ST_ACK && s_reg.scl_s2 |=> sda_oe;
	endproperty
	a_ack_stable: assert property (p_ack_stable) else $error("ack released while clock high");  // R8

	property p_oe_moves_low;
		@(posedge clk) disable iff (!rst_n)
		$changed(sda_oe) && !$past(start_det) && !$past(stop_det) && !$past(reg_lost_i)
		|-> $past(scl_fall);
	endproperty
	a_oe_moves_low: assert property (p_oe_moves_low) else $error("oe moved while clock high");  // R9

	property p_unmapped;
		@(posedge clk) disable iff (!rst_n)
		load_tx && s_reg.ptr > OFS_MASK && !start_det && !stop_det && !reg_lost_i
		|=> s_reg.txbyte == UNMAPPED_BYTE;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not FFh");  // R12

	property p_ctrl_write;
		@(posedge clk) disable iff (!rst_n)
		s_reg.st == ST_RX && s_reg.phase == PH_DATA && scl_rise && s_reg.bitcnt == BIT_LAST
			&& ptr_is_ctrl && !start_det && !stop_det && !reg_lost_i
		|=> s_reg.ctrl[$past(ctrl_idx)] == $past(rx_byte);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("register write lost");  // R13

	property p_rc_clear;
		@(posedge clk) disable iff (!rst_n)
		s_reg.st == ST_RACK && scl_rise && s_reg.ptr == OFS_FLAGS && flag_event_i == 8'h00
			&& !start_det && !stop_det && !reg_lost_i
		|=> (s_reg.flags & $past(s_reg.txbyte)) == 8'h00;
	endproperty
	a_rc_clear: assert property (p_rc_clear) else $error("read flags not cleared");  // R17

	property p_lost;
		@(posedge clk) disable iff (!rst_n)
		reg_lost_i |=> s_reg.ctrl == CTRL_RESET && irq_mask == MASK_RESET;
	endproperty
	a_lost: assert property (p_lost) else $error("register loss not applied");  // R15

endmodule
`default_nettype wire

// [chgip_host_model.sv]
// bus controller model driving clock and data toward the register port
`timescale 1ns/1ps
`default_nettype none
module chgip_host_model (
	input  wire logic clk,
	input  wire logic sda_bus,
	output var logic  scl_o,
	output var logic  sda_low
);
	// half bit in cycles: 32 keeps fast mode at or under 400 kbps, 125 gives 100 kbps
	int half = 32;
	initial begin
		scl_o = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic put_bit(input logic b, output logic s);
		sda_low <= ~b;
		tick(half);
		scl_o <= 1'b1;
		tick(half / 2);
		s = sda_bus;
		tick(half - half / 2);
		scl_o <= 1'b0;
		tick(1);
	endtask
	// data released first, so this also forms a repeated start
	task automatic start_c();
		sda_low <= 1'b0;
		tick(half);
		scl_o <= 1'b1;
		tick(half);
		sda_low <= 1'b1;
		tick(half);
		scl_o <= 1'b0;
		tick(1);
	endtask
	task automatic stop_c();
		sda_low <= 1'b1;
		tick(half);
		scl_o <= 1'b1;
		tick(half);
		sda_low <= 1'b0;
		tick(half);
	endtask
	task automatic wr_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(v[i], s);
		put_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			v[i] = s;
		end
		put_bit(last, s);
	endtask
	task automatic abort_c();
		logic s;
		start_c();
		repeat (3) put_bit(1'b1, s);
		stop_c();
	endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the charger serial register port
`timescale 1ns/1ps
`default_nettype none
module tb;
	import chgip_pkg::*;
	logic       clk, rst_n, scl, sda_low, sda_o, sda_oe, sda_bus, reg_lost, a;
	logic [7:0] st_i, flg_i, f2, d;
	logic [4:0] lvl_i;
	logic [2:0] flt_i, f1;
	logic [3:0] irq_mask, mask;
	logic [7:0] c_out [9];
	logic [7:0] ctl [9];
	logic [7:0] bad [3] = '{8'hd6, 8'hf0, 8'h54};
	int         n_fail, cmp_count;
	// wired-and of both open-drain parties with the pull-up
	assign sda_bus = ~(sda_low | (sda_oe & ~sda_o));
	chgip_host_model host_inst (.clk(clk), .sda_bus(sda_bus), .scl_o(scl), .sda_low(sda_low));
	chgip_charger_i2c_register_port chgip_charger_i2c_register_port_inst (
		.clk                       (clk),
		.rst_n                     (rst_n),
		.scl_i                     (scl),
		.sda_i                     (sda_bus),
		.sda_o                     (sda_o),
		.sda_oe                    (sda_oe),
		.reg_lost_i                (reg_lost),
		.charger_status_i          (st_i),
		.fault_level_i             (lvl_i),
		.fault_event_i             (flt_i),
		.flag_event_i              (flg_i),
		.battery_voltage_ctrl      (c_out[0]),
		.fast_charge_current_ctrl  (c_out[1]),
		.charger_ctrl_first        (c_out[2]),
		.charger_ctrl_second       (c_out[3]),
		.chip_ctrl                 (c_out[4]),
		.timer_input_limit_ctrl    (c_out[5]),
		.shipping_reset_button_ctrl(c_out[6]),
		.system_rail_ctrl          (c_out[7]),
		.thermistor_ctrl           (c_out[8]),
		.irq_mask                  (irq_mask)
	);
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_ack(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [7:0] o);
		if (o == 8'h00) return st_i;
		if (o == 8'h01) return {lvl_i, f1};
		if (o == 8'h02) return f2;
		if (o <= 8'h0b) return ctl[o - 8'h03];
		if (o == 8'h0c) return {mask, IDENT_CODE};
		return 8'hff;
	endfunction
	function automatic void note_wr(input logic [7:0] o, input logic [7:0] v);
		if (o >= 8'h03 && o <= 8'h0b) ctl[o - 8'h03] = v;
		if (o == 8'h0c) mask = v[7:4];
	endfunction
	task automatic load_defaults();
		for (int i = 0; i < 9; i++)
			ctl[i] = CTRL_RESET[i];
		mask = MASK_RESET;
		f1 = 3'h0;
		f2 = 8'h00;
	endtask
	task automatic head(input logic [7:0] o);
		host_inst.start_c();
		host_inst.wr_byte(8'hd4, a);
		chk_ack("addr_ack", 1'b1, a);
		host_inst.wr_byte(o, a);
		chk_ack("ofs_ack", 1'b1, a);
	endtask
	task automatic wr_regs(input logic [7:0] o, input int n);
		head(o);
		repeat (n) begin
			d = 8'($urandom);
			host_inst.wr_byte(d, a);
			chk_ack("data_ack", 1'b1, a);
			note_wr(o, d);
			o++;
		end
		host_inst.stop_c();
	endtask
	task automatic rd_regs(input logic [7:0] o, input int n);
		head(o);
		host_inst.start_c();
		host_inst.wr_byte(8'hd5, a);
		chk_ack("rd_addr_ack", 1'b1, a);
		for (int i = 1; i <= n; i++) begin
			host_inst.rd_byte(i == n, d);
			chk_byte("rd_data", exp_rd(o), d);
			if (o == 8'h01) f1 = 3'h0;
			if (o == 8'h02) f2 = 8'h00;
			o++;
		end
		host_inst.stop_c();
	endtask
	task automatic chk_outs();
		for (int i = 0; i < 9; i++)
			chk_byte("ctrl_out", ctl[i], c_out[i]);
		chk_byte("irq_mask", {4'h0, mask}, {4'h0, irq_mask});
	endtask
	task automatic give_verdict();
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (80000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'he37ddddf));
		rst_n = 1'b0;
		reg_lost = 1'b0;
		st_i = 8'h00;
		lvl_i = 5'h00;
		flt_i = 3'h0;
		flg_i = 8'h00;
		load_defaults();
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		st_i <= 8'($urandom);
		lvl_i <= 5'($urandom);
		repeat (3) @(posedge clk);
		chk_outs();
		flt_i <= 3'($urandom);
		flg_i <= 8'($urandom);
		@(posedge clk);
		f1 = flt_i;
		f2 = flg_i;
		flt_i <= 3'h0;
		flg_i <= 8'h00;
		// neighbouring, ten-bit header and far addresses stay unanswered
		foreach (bad[i]) begin
			host_inst.start_c();
			host_inst.wr_byte(bad[i], a);
			chk_ack("foreign_ack", 1'b0, a);
			host_inst.stop_c();
		end
		wr_regs(8'h03, 10);
		chk_outs();
		rd_regs(8'h00, 16);
		rd_regs(8'h01, 2);
		wr_regs(8'h00, 3);
		wr_regs(8'h0c, 1);
		rd_regs(8'h00, 14);
		host_inst.abort_c();
		host_inst.half = 125;
		wr_regs(8'h07, 2);
		host_inst.half = 32;
		chk_outs();
		rd_regs(8'h06, 3);
		reg_lost <= 1'b1;
		@(posedge clk);
		reg_lost <= 1'b0;
		load_defaults();
		repeat (3) @(posedge clk);
		chk_outs();
		rd_regs(8'h00, 13);
		give_verdict();
	end
endmodule
`default_nettype wire
